// ### design/serial_glue_pkg.sv
package serial_glue_pkg;

  // i/o byte addresses of the four serial controller ports
  localparam logic [15:0] ADDR_A_DATA = 16'h00D8;
  localparam logic [15:0] ADDR_B_DATA = 16'h00DA;
  localparam logic [15:0] ADDR_A_CTL = 16'h00DC;
  localparam logic [15:0] ADDR_B_CTL = 16'h00DE;
  // parallel port chip, port c, held by the glue itself
  localparam logic [15:0] ADDR_PORT_C = 16'h00CC;

  // port c layout and reset value; bit 6 is the loopback select
  localparam int LOOPBACK_BIT = 6;
  localparam logic [7:0] PORTC_RESET = 8'h40;
  localparam logic [7:0] PORTC_ONLINE = 8'h00;

  // value returned for refused or unmapped reads
  localparam logic [7:0] READ_FILL = 8'hFF;

  // connector levels held while channel a is looped back: rts off, clock low, txd mark
  localparam logic [2:0] LOOP_PIN_IDLE = 3'h1;

  // controller command and pointer values for the start-up sequence
  localparam logic [7:0] CHAN_RESET_CMD = 8'h18;
  localparam logic [7:0] PTR_WR1 = 8'h01;
  localparam logic [7:0] PTR_WR2 = 8'h02;
  localparam logic [7:0] PTR_WR3 = 8'h03;
  localparam logic [7:0] PTR_WR4 = 8'h04;
  localparam logic [7:0] PTR_WR5 = 8'h05;
  localparam logic [7:0] CHAN_B_MODE_VALUE = 8'h4C;
  localparam logic [7:0] CHAN_B_INTERRUPT_VALUE = 8'h1C;
  localparam logic [7:0] CHAN_A_BUS_IF_VALUE = 8'h34;
  localparam logic [7:0] CHAN_B_VECTOR_VALUE = 8'h30;
  localparam logic [7:0] CHAN_B_RECEIVE_VALUE = 8'hC1;
  localparam logic [7:0] CHAN_B_TRANSMIT_VALUE = 8'hFA;
  localparam logic [3:0] INIT_LAST = 4'hE;

  // which serial controller port an access goes to
  typedef enum logic [1:0] {
    PORT_A_DATA = 2'b00,
    PORT_B_DATA = 2'b01,
    PORT_A_CTL = 2'b10,
    PORT_B_CTL = 2'b11
  } port_sel_e;

  // host end sequencing
  typedef enum logic [1:0] {
    HOST_INIT = 2'b00,
    HOST_IDLE = 2'b01,
    HOST_WAIT = 2'b10
  } host_state_e;

endpackage

// ### design/io_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// byte-wide i/o bus between host processor end and board glue end
interface io_bus_if;
  logic [15:0] ioAddr; // port address
  logic ioWrite; // one-cycle write strobe
  logic ioRead; // one-cycle read strobe
  logic ioWord; // access asks for a word
  logic [7:0] ioWrData; // write data
  logic [7:0] ioRdData; // read data, valid with ioRdValid
  logic ioRdValid; // one-cycle read answer

  modport host (
    output ioAddr, ioWrite, ioRead, ioWord, ioWrData,
    input ioRdData, ioRdValid
  );
  modport device (
    input ioAddr, ioWrite, ioRead, ioWord, ioWrData,
    output ioRdData, ioRdValid
  );
endinterface
`default_nettype wire

// ### design/serial_glue_device.sv
`timescale 1ns/1ps
`default_nettype none
module serial_glue_device (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  io_bus_if.device bus,
  output logic [1:0] portSel,
  output logic ctlWrite,
  output logic ctlRead,
  output logic [7:0] ctlWrData,
  input wire logic [7:0] ctlRdData,
  input wire logic ctrlRts,
  input wire logic ctrlTxc,
  input wire logic ctrlTxd,
  output logic ctrlCts,
  output logic ctrlRxc,
  output logic ctrlRxd,
  output logic ctrlSyncIn,
  output logic ctrlDmaAck_n,
  input wire logic pinCts,
  input wire logic pinRxc,
  input wire logic pinRxd,
  output logic pinRts,
  output logic pinTxc,
  output logic pinTxd,
  output logic serialLoopbackSelect
);

  // whole state of the glue in one word
  typedef struct packed {
    logic [2:0] syncMeta; // first synchroniser stage, connector receivers
    logic [2:0] syncLine; // second stage, safe to use
    logic [7:0] portC; // port c image, bit 6 selects loopback
    serial_glue_pkg::port_sel_e portSel; // target port of the current access
    logic ctlWrite; // write strobe to the controller
    logic ctlRead; // read strobe to the controller
    logic [7:0] ctlWrData; // write data to the controller
    logic readPend; // a read answer is due at the next edge
    logic readSerial; // answer comes from the controller
    logic [7:0] localData; // answer when not from the controller
    logic [7:0] rdData; // read answer to the host
    logic rdValid; // read answer strobe
    logic [2:0] toCtrl; // cts, rxc, rxd into channel a
    logic [2:0] toPins; // rts, txc, txd toward the connector
  } dev_state_s;

  dev_state_s stateReg;
  dev_state_s stateNext;

  // next state: sync, loopback mux, address decode, read answer
  always_comb begin
    logic isAccess;
    logic isSerial;
    logic isPortC;
    serial_glue_pkg::port_sel_e sel;
    isAccess = 1'b0;
    isSerial = 1'b0;
    isPortC = 1'b0;
    sel = serial_glue_pkg::PORT_A_DATA;
    stateNext = stateReg;
    // strobes last one cycle unless renewed
    stateNext.ctlWrite = 1'b0;
    stateNext.ctlRead = 1'b0;
    stateNext.readPend = 1'b0;
    stateNext.rdValid = 1'b0;

    // connector receivers come from off-board: two flops before any use
    stateNext.syncMeta = {pinCts, pinRxc, pinRxd};
    stateNext.syncLine = stateReg.syncMeta;

    // loopback multiplexer; controller outputs share our clock, so no sync on them
    if (stateReg.portC[serial_glue_pkg::LOOPBACK_BIT]) begin
      // looped: channel a hears itself
      stateNext.toCtrl = {ctrlRts, ctrlTxc, ctrlTxd};
      // connector held quiet so the far end sees no stray traffic
      stateNext.toPins = serial_glue_pkg::LOOP_PIN_IDLE;
    end else begin
      // on-line: external receivers in, transmit signals out
      stateNext.toCtrl = stateReg.syncLine;
      stateNext.toPins = {ctrlRts, ctrlTxc, ctrlTxd};
    end

    // address decode of a byte access
    isAccess = bus.ioWrite || bus.ioRead;
    if (bus.ioWord) begin
      // word access to any port is refused: no strobe, read gets fill
      isSerial = 1'b0;
      isPortC = 1'b0;
    end else if (bus.ioAddr == serial_glue_pkg::ADDR_A_DATA) begin
      isSerial = 1'b1;
      sel = serial_glue_pkg::PORT_A_DATA;
    end else if (bus.ioAddr == serial_glue_pkg::ADDR_B_DATA) begin
      isSerial = 1'b1;
      sel = serial_glue_pkg::PORT_B_DATA;
    end else if (bus.ioAddr == serial_glue_pkg::ADDR_A_CTL) begin
      isSerial = 1'b1;
      sel = serial_glue_pkg::PORT_A_CTL;
    end else if (bus.ioAddr == serial_glue_pkg::ADDR_B_CTL) begin
      isSerial = 1'b1;
      sel = serial_glue_pkg::PORT_B_CTL;
    end else if (bus.ioAddr == serial_glue_pkg::ADDR_PORT_C) begin
      isPortC = 1'b1;
    end else begin
      // unmapped: writes dropped, reads answered with fill
      isSerial = 1'b0;
    end

    // write wins if a broken host strobes both at once
    if (isAccess && bus.ioWrite) begin
      if (isSerial) begin
        // pass the byte to the chosen controller register
        stateNext.portSel = sel;
        stateNext.ctlWrite = 1'b1;
        stateNext.ctlWrData = bus.ioWrData;
      end else if (isPortC) begin
        // software steers loopback through bit 6
        stateNext.portC = bus.ioWrData;
      end
    end else if (isAccess) begin
      // every read gets exactly one answer two edges later
      stateNext.readPend = 1'b1;
      stateNext.readSerial = isSerial;
      stateNext.localData = isPortC ? stateReg.portC : serial_glue_pkg::READ_FILL;
      if (isSerial) begin
        stateNext.portSel = sel;
        stateNext.ctlRead = 1'b1;
      end
    end

    // controller answers during its read strobe; capture it then
    if (stateReg.readPend) begin
      stateNext.rdValid = 1'b1;
      stateNext.rdData = stateReg.readSerial ? ctlRdData : stateReg.localData;
    end
  end

  // register the state; clock enable freezes all of it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg.syncMeta <= 3'h0;
      stateReg.syncLine <= 3'h0;
      // channel a starts looped back until software says otherwise
      stateReg.portC <= serial_glue_pkg::PORTC_RESET;
      stateReg.portSel <= serial_glue_pkg::PORT_A_DATA;
      stateReg.ctlWrite <= 1'b0;
      stateReg.ctlRead <= 1'b0;
      stateReg.ctlWrData <= 8'h00;
      stateReg.readPend <= 1'b0;
      stateReg.readSerial <= 1'b0;
      stateReg.localData <= 8'h00;
      stateReg.rdData <= 8'h00;
      stateReg.rdValid <= 1'b0;
      stateReg.toCtrl <= 3'h0;
      stateReg.toPins <= serial_glue_pkg::LOOP_PIN_IDLE;
    end else if (clkEn) begin
      stateReg <= stateNext;
    end
  end

  // controller access port
  assign portSel = stateReg.portSel;
  assign ctlWrite = stateReg.ctlWrite;
  assign ctlRead = stateReg.ctlRead;
  assign ctlWrData = stateReg.ctlWrData;

  // host read answer
  assign bus.ioRdData = stateReg.rdData;
  assign bus.ioRdValid = stateReg.rdValid;

  // channel a inputs and connector outputs, all registered
  assign ctrlCts = stateReg.toCtrl[2];
  assign ctrlRxc = stateReg.toCtrl[1];
  assign ctrlRxd = stateReg.toCtrl[0];
  assign pinRts = stateReg.toPins[2];
  assign pinTxc = stateReg.toPins[1];
  assign pinTxd = stateReg.toPins[0];

  // loopback select seen by board logic
  assign serialLoopbackSelect = stateReg.portC[serial_glue_pkg::LOOPBACK_BIT];

  // sync-detect and dma acknowledge are not wired, held inactive
  assign ctrlSyncIn = 1'b0;
  assign ctrlDmaAck_n = 1'b1;

endmodule
`default_nettype wire

// ### design/serial_glue_host.sv
`timescale 1ns/1ps
`default_nettype none
module serial_glue_host (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  io_bus_if.host bus,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdWrite,
  input wire logic cmdWord,
  input wire logic [15:0] cmdAddr,
  input wire logic [7:0] cmdData,
  output logic rspValid,
  output logic [7:0] rspData,
  output logic initDone
);

  // whole state of the host end
  typedef struct packed {
    serial_glue_pkg::host_state_e state; // sequencer state
    logic [3:0] initIdx; // next start-up step
    logic [15:0] ioAddr; // address on the bus
    logic [7:0] ioWrData; // write data on the bus
    logic ioWrite; // write strobe
    logic ioRead; // read strobe
    logic ioWord; // word flag
    logic rspValid; // read answer to the user
    logic [7:0] rspData; // read data to the user
  } host_state_s;

  host_state_s stateReg;
  host_state_s stateNext;

  // start-up sequence: {address, data} per step
  function automatic logic [23:0] initStep(input logic [3:0] idx);
    logic [23:0] step;
    step = {serial_glue_pkg::ADDR_PORT_C, serial_glue_pkg::PORTC_ONLINE};
    case (idx)
      // reset both channels first
      4'h0: step = {serial_glue_pkg::ADDR_A_CTL, serial_glue_pkg::CHAN_RESET_CMD};
      4'h1: step = {serial_glue_pkg::ADDR_B_CTL, serial_glue_pkg::CHAN_RESET_CMD};
      // each register: pointer byte, then value byte
      4'h2: step = {serial_glue_pkg::ADDR_B_CTL, serial_glue_pkg::PTR_WR4};
      4'h3: step = {serial_glue_pkg::ADDR_B_CTL, serial_glue_pkg::CHAN_B_MODE_VALUE};
      4'h4: step = {serial_glue_pkg::ADDR_B_CTL, serial_glue_pkg::PTR_WR1};
      4'h5: step = {serial_glue_pkg::ADDR_B_CTL, serial_glue_pkg::CHAN_B_INTERRUPT_VALUE};
      4'h6: step = {serial_glue_pkg::ADDR_A_CTL, serial_glue_pkg::PTR_WR2};
      4'h7: step = {serial_glue_pkg::ADDR_A_CTL, serial_glue_pkg::CHAN_A_BUS_IF_VALUE};
      4'h8: step = {serial_glue_pkg::ADDR_B_CTL, serial_glue_pkg::PTR_WR2};
      4'h9: step = {serial_glue_pkg::ADDR_B_CTL, serial_glue_pkg::CHAN_B_VECTOR_VALUE};
      4'hA: step = {serial_glue_pkg::ADDR_B_CTL, serial_glue_pkg::PTR_WR3};
      4'hB: step = {serial_glue_pkg::ADDR_B_CTL, serial_glue_pkg::CHAN_B_RECEIVE_VALUE};
      4'hC: step = {serial_glue_pkg::ADDR_B_CTL, serial_glue_pkg::PTR_WR5};
      4'hD: step = {serial_glue_pkg::ADDR_B_CTL, serial_glue_pkg::CHAN_B_TRANSMIT_VALUE};
      // last, take channel a out of loopback before any traffic
      default: step = {serial_glue_pkg::ADDR_PORT_C, serial_glue_pkg::PORTC_ONLINE};
    endcase
    return step;
  endfunction

  // next state: start-up writes, then user commands
  always_comb begin
    logic [23:0] step;
    step = initStep(stateReg.initIdx);
    stateNext = stateReg;
    stateNext.ioWrite = 1'b0;
    stateNext.ioRead = 1'b0;
    stateNext.rspValid = 1'b0;
    case (stateReg.state)
      serial_glue_pkg::HOST_INIT: begin
        // one byte write per cycle; the glue takes one every cycle
        stateNext.ioAddr = step[23:8];
        stateNext.ioWrData = step[7:0];
        stateNext.ioWord = 1'b0;
        stateNext.ioWrite = 1'b1;
        stateNext.initIdx = stateReg.initIdx + 4'h1;
        if (stateReg.initIdx == serial_glue_pkg::INIT_LAST) begin
          stateNext.state = serial_glue_pkg::HOST_IDLE;
        end
      end
      serial_glue_pkg::HOST_IDLE: begin
        if (cmdValid) begin
          // word flag passed through so the glue can refuse it
          stateNext.ioAddr = cmdAddr;
          stateNext.ioWrData = cmdData;
          stateNext.ioWord = cmdWord;
          if (cmdWrite) begin
            stateNext.ioWrite = 1'b1;
          end else begin
            stateNext.ioRead = 1'b1;
            stateNext.state = serial_glue_pkg::HOST_WAIT;
          end
        end
      end
      serial_glue_pkg::HOST_WAIT: begin
        // the glue always answers, so this wait is bounded
        if (bus.ioRdValid) begin
          stateNext.rspValid = 1'b1;
          stateNext.rspData = bus.ioRdData;
          stateNext.state = serial_glue_pkg::HOST_IDLE;
        end
      end
      default: begin
        stateNext.state = serial_glue_pkg::HOST_IDLE;
      end
    endcase
  end

  // register the state; clock enable freezes all of it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg.state <= serial_glue_pkg::HOST_INIT;
      stateReg.initIdx <= 4'h0;
      stateReg.ioAddr <= 16'h0000;
      stateReg.ioWrData <= 8'h00;
      stateReg.ioWrite <= 1'b0;
      stateReg.ioRead <= 1'b0;
      stateReg.ioWord <= 1'b0;
      stateReg.rspValid <= 1'b0;
      stateReg.rspData <= 8'h00;
    end else if (clkEn) begin
      stateReg <= stateNext;
    end
  end

  // user handshake and bus drive
  assign cmdReady = clkEn && (stateReg.state == serial_glue_pkg::HOST_IDLE);
  assign rspValid = stateReg.rspValid;
  assign rspData = stateReg.rspData;
  assign initDone = (stateReg.state != serial_glue_pkg::HOST_INIT);
  assign bus.ioAddr = stateReg.ioAddr;
  assign bus.ioWrData = stateReg.ioWrData;
  assign bus.ioWrite = stateReg.ioWrite;
  assign bus.ioRead = stateReg.ioRead;
  assign bus.ioWord = stateReg.ioWord;

endmodule
`default_nettype wire

// ### tb/serial_glue_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module serial_glue_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic ioWord,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic ioRdValid,
  input wire logic [1:0] portSel,
  input wire logic ctlWrite,
  input wire logic ctlRead,
  input wire logic [7:0] ctlWrData,
  input wire logic [7:0] ctlRdData,
  input wire logic ctrlRts,
  input wire logic ctrlTxc,
  input wire logic ctrlTxd,
  input wire logic ctrlCts,
  input wire logic ctrlRxc,
  input wire logic ctrlRxd,
  input wire logic ctrlSyncIn,
  input wire logic ctrlDmaAck_n,
  input wire logic pinCts,
  input wire logic pinRxc,
  input wire logic pinRxd,
  input wire logic pinRts,
  input wire logic pinTxc,
  input wire logic pinTxd,
  input wire logic serialLoopbackSelect
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // address classes; a word flag spoils any access
  logic isData;
  logic isCtl;
  logic byteWr;
  logic byteRd;
  assign isData = ioAddr == serial_glue_pkg::ADDR_A_DATA || ioAddr == serial_glue_pkg::ADDR_B_DATA;
  assign isCtl = ioAddr == serial_glue_pkg::ADDR_A_CTL || ioAddr == serial_glue_pkg::ADDR_B_CTL;
  assign byteWr = ioWrite && !ioWord;
  assign byteRd = ioRead && !ioWrite && !ioWord;

  a_data_decode: assert property (byteWr && isData |=> ctlWrite &&
    portSel == $past(ioAddr[2:1]) && ctlWrData == $past(ioWrData))
    else $error("data write lost");
  a_ctl_decode: assert property (byteWr && isCtl |=> ctlWrite &&
    portSel == $past(ioAddr[2:1]) && ctlWrData == $past(ioWrData))
    else $error("control write lost");
  a_read_path: assert property (byteRd && (isData || isCtl) |=> ctlRead ##1
    ioRdValid && ioRdData == $past(ctlRdData)) else $error("read path wrong");
  a_word_block: assert property ((ioWrite || ioRead) && ioWord |=> !ctlWrite && !ctlRead)
    else $error("word access passed");
  a_word_fill: assert property (ioRead && !ioWrite && ioWord |-> ##2 ioRdValid &&
    ioRdData == serial_glue_pkg::READ_FILL) else $error("word read answer");
  a_loop_route: assert property (serialLoopbackSelect |=>
    {ctrlCts, ctrlRxc, ctrlRxd} == $past({ctrlRts, ctrlTxc, ctrlTxd})) else $error("loop route");
  a_loop_pins: assert property (serialLoopbackSelect |=>
    {pinRts, pinTxc, pinTxd} == serial_glue_pkg::LOOP_PIN_IDLE) else $error("pins in loop");
  a_online_out: assert property (!serialLoopbackSelect |=>
    {pinRts, pinTxc, pinTxd} == $past({ctrlRts, ctrlTxc, ctrlTxd})) else $error("pins on-line");
  a_online_in: assert property (!serialLoopbackSelect |=>
    {ctrlCts, ctrlRxc, ctrlRxd} == $past({pinCts, pinRxc, pinRxd}, 3))
    else $error("inputs on-line");
  a_reset_loop: assert property (!$past(rst_n) |-> serialLoopbackSelect)
    else $error("no loop after reset");
  a_select_bit: assert property (byteWr && ioAddr == serial_glue_pkg::ADDR_PORT_C
    |=> serialLoopbackSelect == $past(ioWrData[serial_glue_pkg::LOOPBACK_BIT]))
    else $error("select bit");
  a_unused_feat: assert property (ctrlSyncIn == 1'b0 && ctrlDmaAck_n == 1'b1)
    else $error("dma or sync used");

  // main scenarios reached
  c_ser_read: cover property (byteRd && isCtl ##2 ioRdValid);
  c_word: cover property (ioWrite && ioWord);
  c_online: cover property ($fell(serialLoopbackSelect));
  c_loop_again: cover property ($rose(serialLoopbackSelect));
endmodule
`default_nettype wire

// ### tb/tb_serial_port_glue_loopback.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_glue_loopback;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic cmdValid = 1'b0;
  logic cmdWrite = 1'b0;
  logic cmdWord = 1'b0;
  logic [15:0] cmdAddr = 16'h0000;
  logic [7:0] cmdData = 8'h00;
  logic [7:0] ctlRdData = 8'h00;
  logic [7:0] rdAnswer = 8'h00; // byte the controller stand-in returns
  logic ctrlRts = 1'b0, ctrlTxc = 1'b0, ctrlTxd = 1'b1;
  logic pinCts = 1'b0, pinRxc = 1'b0, pinRxd = 1'b1;
  logic cmdReady, rspValid, initDone, ctlWrite, ctlRead, ctrlCts, ctrlRxc, ctrlRxd;
  logic ctrlSyncIn, ctrlDmaAck_n, pinRts, pinTxc, pinTxd, serialLoopbackSelect;
  logic [7:0] rspData;
  logic [7:0] ctlWrData;
  logic [1:0] portSel;
  integer seed = 32'h6C4D;
  int mismatches = 0;
  int check_count = 0;
  logic wiggle = 1'b0; // random line activity on/off
  logic [7:0] portC; // model of the port c image
  logic [9:0] exq [$]; // expected {portSel, data} controller writes
  // start-up bytes: channel resets, then the twelve setup bytes
  logic [9:0] initSeq [14] = '{10'h218, 10'h318, 10'h304, 10'h34C, 10'h301, 10'h31C, 10'h202,
    10'h234, 10'h302, 10'h330, 10'h303, 10'h3C1, 10'h305, 10'h3FA};
  logic [15:0] addrs [4] = '{16'h00D8, 16'h00DA, 16'h00DC, 16'h00DE};

  io_bus_if i_io_bus_if ();
  serial_glue_host i_serial_glue_host (.core_clk, .rst_n, .clkEn, .bus(i_io_bus_if.host),
    .cmdValid, .cmdReady, .cmdWrite, .cmdWord, .cmdAddr, .cmdData, .rspValid, .rspData,
    .initDone);
  serial_glue_device i_serial_glue_device (.core_clk, .rst_n, .clkEn,
    .bus(i_io_bus_if.device), .portSel, .ctlWrite, .ctlRead, .ctlWrData, .ctlRdData,
    .ctrlRts, .ctrlTxc, .ctrlTxd, .ctrlCts, .ctrlRxc, .ctrlRxd, .ctrlSyncIn, .ctrlDmaAck_n,
    .pinCts, .pinRxc, .pinRxd, .pinRts, .pinTxc, .pinTxd, .serialLoopbackSelect);
  serial_glue_monitor i_monitor (.core_clk, .rst_n, .ioAddr(i_io_bus_if.ioAddr),
    .ioWrite(i_io_bus_if.ioWrite), .ioRead(i_io_bus_if.ioRead), .ioWord(i_io_bus_if.ioWord),
    .ioWrData(i_io_bus_if.ioWrData), .ioRdData(i_io_bus_if.ioRdData),
    .ioRdValid(i_io_bus_if.ioRdValid), .portSel, .ctlWrite, .ctlRead, .ctlWrData, .ctlRdData,
    .ctrlRts, .ctrlTxc, .ctrlTxd, .ctrlCts, .ctrlRxc, .ctrlRxd, .ctrlSyncIn, .ctrlDmaAck_n,
    .pinCts, .pinRxc, .pinRxd, .pinRts, .pinTxc, .pinTxd, .serialLoopbackSelect);

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  // random line levels on both sides of the mux
  always @(posedge core_clk) begin
    if (wiggle) begin
      {ctrlRts, ctrlTxc, ctrlTxd, pinCts, pinRxc, pinRxd} <= 6'($random(seed));
    end
  end

  // controller stand-in: the answer stands only in the cycle of its read strobe,
  // its inverse otherwise, so a capture one cycle off shows up as a mismatch
  always @(posedge core_clk) begin
    if (i_io_bus_if.ioRead === 1'b1 && i_io_bus_if.ioWord === 1'b0) begin
      ctlRdData <= rdAnswer;
    end else begin
      ctlRdData <= ~rdAnswer;
    end
  end

  // one comparison, counted; prints its own mismatch
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // every controller write must be the next one the model expects
  always @(posedge core_clk) begin
    if (ctlWrite === 1'b1) begin
      if (exq.size() == 0) begin
        chk(10'h000, 10'h3FF, "unexpected write");
      end else begin
        chk({portSel, ctlWrData}, exq.pop_front(), "ctl write");
      end
    end
  end

  // one user command; reads are compared with the model
  task automatic cmd(input logic w, input logic wd, input logic [15:0] a, input logic [7:0] d);
    int n;
    logic [7:0] exp;
    logic [7:0] rdv;
    logic ser;
    ser = a inside {16'h00D8, 16'h00DA, 16'h00DC, 16'h00DE};
    rdv = 8'($random(seed));
    exp = 8'hFF; // refused and unmapped reads
    if (w && !wd && ser) exq.push_back({a[2:1], d});
    if (w && !wd && a == 16'h00CC) portC = d;
    if (!wd && ser) exp = rdv;
    if (!wd && a == 16'h00CC) exp = portC;
    rdAnswer = rdv;
    cmdValid <= 1'b1;
    cmdWrite <= w;
    cmdWord <= wd;
    cmdAddr <= a;
    cmdData <= d;
    n = 0;
    @(posedge core_clk);
    while (cmdReady !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    // a command never taken counts as a mismatch
    chk({9'h000, cmdReady}, 10'h001, "command taken");
    cmdValid <= 1'b0;
    if (!w) begin
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (rspValid !== 1'b1 && n < 20);
      chk({9'h000, rspValid}, 10'h001, "read answer");
      chk({2'h0, rspData}, {2'h0, exp}, "read data");
    end
    @(posedge core_clk);
  endtask

  // reset, start-up sequence, loopback released at the end
  task automatic do_reset();
    int n;
    rst_n <= 1'b0;
    exq.delete();
    foreach (initSeq[i]) exq.push_back(initSeq[i]);
    portC = 8'h00;
    repeat (2) @(posedge core_clk);
    chk({9'h000, serialLoopbackSelect}, 10'h001, "loop at reset");
    rst_n <= 1'b1;
    n = 0;
    while (initDone !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    chk({9'h000, initDone}, 10'h001, "start-up done");
    repeat (3) @(posedge core_clk);
    chk(10'(exq.size()), 10'h000, "init bytes left");
    chk({9'h000, serialLoopbackSelect}, 10'h000, "on-line after init");
  endtask

  // hold fixed levels, then see where they land
  task automatic hold_lines(input logic [2:0] tx, input logic [2:0] rx, input int cyc);
    wiggle = 1'b0;
    @(posedge core_clk);
    {ctrlRts, ctrlTxc, ctrlTxd} <= tx;
    {pinCts, pinRxc, pinRxd} <= rx;
    repeat (cyc) @(posedge core_clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (6000) @(posedge core_clk);
    mismatches++;
    $display("[FAIL] %0t watchdog ran out", $time);
    print_verdict();
  end

  initial begin
    do_reset();
    wiggle = 1'b1;
    foreach (addrs[i]) cmd(1'b1, 1'b0, addrs[i], 8'($random(seed)));
    cmd(1'b1, 1'b1, 16'h00DA, 8'h55);
    cmd(1'b1, 1'b0, 16'h00E0, 8'h66);
    foreach (addrs[i]) cmd(1'b0, 1'b0, addrs[i], 8'h00);
    cmd(1'b0, 1'b1, 16'h00DC, 8'h00);
    cmd(1'b0, 1'b0, 16'h00E0, 8'h00);
    cmd(1'b0, 1'b0, 16'h00CC, 8'h00);
    // back into loopback: tx side returns, connector sits idle
    cmd(1'b1, 1'b0, 16'h00CC, 8'h40);
    hold_lines(3'h5, 3'h2, 5);
    chk({7'h00, ctrlCts, ctrlRxc, ctrlRxd}, 10'h005, "looped inputs");
    chk({7'h00, pinRts, pinTxc, pinTxd}, 10'h001, "idle pins");
    cmd(1'b0, 1'b0, 16'h00CC, 8'h00);
    // on-line again: connector feeds the inputs
    cmd(1'b1, 1'b0, 16'h00CC, 8'h00);
    hold_lines(3'h6, 3'h3, 6);
    chk({7'h00, ctrlCts, ctrlRxc, ctrlRxd}, 10'h003, "line inputs");
    chk({7'h00, pinRts, pinTxc, pinTxd}, 10'h006, "line outputs");
    wiggle = 1'b1;
    // second reset in mid-run restores loopback and reruns start-up
    do_reset();
    repeat (4) @(posedge core_clk);
    print_verdict();
  end
endmodule
`default_nettype wire
